/* File: rtl/clock_gen_mode_sequencer.sv */
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module clock_gen_mode_sequencer import clkgen_pkg::*; #(
   parameter int LOCK_CYC = LOCK_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // strap and serial pins
   input wire logic ref_source_select_i,
   input wire logic sda_i,
   input wire logic clock_or_powerdown_pin_i,
   input wire logic mixed_mode_i,
   input wire logic [NUM_BANKS*FS_W-1:0] freq_select_pins_i,
   // reference inputs
   input wire logic ref_in_true_i,
   input wire logic ref_in_comp_i,
   // analog enables and pll stable status
   output logic xtal_osc_en_o,
   output logic diff_buf_en_o,
   output logic ldo_en_o,
   output logic pll_en_o,
   output logic pll_stable_o,
   // bank outputs
   output logic [NUM_BANKS-1:0] bank_out_a_o,
   output logic [NUM_BANKS-1:0] bank_out_b_o,
   output logic [NUM_BANKS-1:0] bank_is_pecl_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      seq_state_type seq;
      logic strap_exit;
      logic [2:0] ctrl;
      logic ack;
      logic [31:0] rdat;
      logic ref_lvl;
      logic xtal_en;
      logic diff_en;
      logic ldo_en;
   } top_state_type;

   top_state_type s_ff;
   top_state_type nxt_s;

   logic stable;
   logic strap;
   logic pd_pin;
   logic pd_any;
   logic bus_req;
   logic bus_wr;
   logic release_ok;
   logic live;
   logic bypass;
   logic [NUM_BANKS*FS_W-1:0] sel_all;
   logic [NUM_BANKS-1:0] run_all;

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------

   // strap mode lasts until the data line is once seen high
   assign strap = !s_ff.strap_exit;
   // the pd meaning of the clock pin exists only while data is low in strap mode
   assign pd_pin = strap && !sda_i && clock_or_powerdown_pin_i;
   assign pd_any = pd_pin || s_ff.ctrl[CTRL_PD_BIT];
   // bank release waits for the pll; mixed-mode pin only counts after strap exit
   assign release_ok = (s_ff.seq == SEQ_RUN) && stable && (strap || mixed_mode_i);
   // live select pins only in strap mode; afterwards the pins are read only at preload
   assign live = strap && (s_ff.seq == SEQ_RUN);
   // bypass reachable only through the register interface
   assign bypass = s_ff.ctrl[CTRL_BYPASS_BIT] && s_ff.strap_exit;
   assign bus_req = wb_cyc_i && wb_stb_i;
   assign bus_wr = bus_req && wb_we_i && s_ff.ack;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] rd;
      rd = RD_ZERO;
      nxt_s = s_ff;
      // data line high once leaves strap mode for good
      if (sda_i) begin
         nxt_s.strap_exit = 1'b1;
      end
      // power sequencer
      unique case (s_ff.seq)
         SEQ_DOWN: begin
            if (!pd_any) begin
               nxt_s.seq = SEQ_PRELOAD;
            end
         end
         SEQ_PRELOAD: begin
            nxt_s.seq = SEQ_LOCK;
         end
         SEQ_LOCK: begin
            if (stable) begin
               nxt_s.seq = SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            nxt_s.seq = SEQ_RUN;
         end
      endcase
      if (pd_any) begin
         nxt_s.seq = SEQ_DOWN;
      end
      // analog enables: regulators and pll off in power-down
      nxt_s.ldo_en = (nxt_s.seq != SEQ_DOWN);
      nxt_s.xtal_en = nxt_s.ldo_en && !ref_source_select_i;
      nxt_s.diff_en = nxt_s.ldo_en && ref_source_select_i;
      // reference level seen by the bypass path
      if (ref_source_select_i) begin
         nxt_s.ref_lvl = ref_in_true_i && !ref_in_comp_i;
      end else begin
         nxt_s.ref_lvl = ref_in_true_i;
      end
      // wishbone: answer one cycle after the request, drop ack the next
      nxt_s.ack = bus_req && !s_ff.ack;
      if (bus_req && !s_ff.ack && !wb_we_i) begin
         unique case (wb_adr_i)
            CTRL_OFS: begin
               rd[2:0] = s_ff.ctrl;
            end
            STAT_OFS: begin
               rd[STAT_RUN_BIT] = (s_ff.seq == SEQ_RUN);
               rd[STAT_STABLE_BIT] = stable;
               rd[STAT_STRAP_BIT] = strap;
               rd[STAT_DOWN_BIT] = (s_ff.seq == SEQ_DOWN);
               rd[STAT_REFSEL_BIT] = ref_source_select_i;
            end
            SEL_OFS: begin
               rd[NUM_BANKS*FS_W-1:0] = sel_all;
               rd[NUM_BANKS*FS_W+NUM_BANKS-1:NUM_BANKS*FS_W] = run_all;
            end
            default: begin
               rd = RD_ZERO;
            end
         endcase
         nxt_s.rdat = rd;
      end
      // write takes effect at the edge where ack is seen
      if (bus_wr && (wb_adr_i == CTRL_OFS) && wb_sel_i[0]) begin
         nxt_s.ctrl = wb_dat_i[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_ff <= '{seq: SEQ_PRELOAD, strap_exit: 1'b0, ctrl: CTRL_RST, ack: 1'b0,
                   rdat: RD_ZERO, ref_lvl: 1'b0, xtal_en: 1'b0, diff_en: 1'b0,
                   ldo_en: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------------------------------
   // pll stable timer
   // ----------------------------------------------------------------
   lock_timer #(
      .CYCLES(LOCK_CYC)
   ) u_lock (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i((s_ff.seq == SEQ_LOCK) || (s_ff.seq == SEQ_RUN)),
      .stable_o(stable)
   );

   // ----------------------------------------------------------------
   // output banks
   // ----------------------------------------------------------------
   for (genvar k = 0; k < NUM_BANKS; k++) begin : g_bank
      bank_ctrl_if bif ();
      assign bif.preload = (s_ff.seq == SEQ_PRELOAD);
      assign bif.release_ok = release_ok;
      assign bif.live = live;
      assign bif.bypass = (k == 0) ? bypass : 1'b0;
      assign bif.bypass_pecl = s_ff.ctrl[CTRL_BYP_PECL_BIT];
      assign bif.ref_lvl = s_ff.ref_lvl;
      assign bif.fs = freq_select_pins_i[k*FS_W +: FS_W];
      assign sel_all[k*FS_W +: FS_W] = bif.sel;
      assign run_all[k] = bif.running;
      assign bank_out_a_o[k] = bif.out_a;
      assign bank_out_b_o[k] = bif.out_b;
      assign bank_is_pecl_o[k] = bif.pecl;
      bank_channel #(
         .IDX(k),
         .HOLD(FS_HOLD_CYCLES)
      ) u_bank (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .b(bif.bank)
      );
   end

   // registered outputs
   assign wb_ack_o = s_ff.ack;
   assign wb_dat_o = s_ff.rdat;
   assign xtal_osc_en_o = s_ff.xtal_en;
   assign diff_buf_en_o = s_ff.diff_en;
   assign ldo_en_o = s_ff.ldo_en;
   assign pll_en_o = s_ff.ldo_en;
   assign pll_stable_o = stable;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_strap_exit;
      sda_i |=> s_ff.strap_exit [*2];
   endproperty
   a_strap_exit: assert property (p_strap_exit) else $error("strap mode not left");

   property p_pd_pin;
      pd_pin |=> (s_ff.seq == SEQ_DOWN) && !ldo_en_o;
   endproperty
   a_pd_pin: assert property (p_pd_pin) else $error("pd pin ignored");

   property p_pd_off;
      (s_ff.seq == SEQ_DOWN) && pd_any |=> !ldo_en_o && !pll_en_o && !xtal_osc_en_o;
   endproperty
   a_pd_off: assert property (p_pd_off) else $error("regulators on in power-down");

   property p_wake;
      (s_ff.seq == SEQ_DOWN) && !pd_any
         |=> (s_ff.seq == SEQ_PRELOAD) ##1 (s_ff.seq == SEQ_LOCK || s_ff.seq == SEQ_DOWN);
   endproperty
   a_wake: assert property (p_wake) else $error("wake skips preload");

   property p_reg_pd;
      s_ff.ctrl[CTRL_PD_BIT] |=> (s_ff.seq == SEQ_DOWN);
   endproperty
   a_reg_pd: assert property (p_reg_pd) else $error("register pd ignored");

   property p_xtal;
      !ref_source_select_i && (nxt_s.seq != SEQ_DOWN) |=> xtal_osc_en_o && !diff_buf_en_o;
   endproperty
   a_xtal: assert property (p_xtal) else $error("crystal path not selected");

   property p_diff;
      ref_source_select_i && (nxt_s.seq != SEQ_DOWN) |=> diff_buf_en_o && !xtal_osc_en_o;
   endproperty
   a_diff: assert property (p_diff) else $error("diff buffer not selected");

   property p_mmc_ignored;
      strap && (s_ff.seq == SEQ_RUN) && stable |-> release_ok;
   endproperty
   a_mmc_ignored: assert property (p_mmc_ignored) else $error("mixed pin used in strap");

   property p_gate;
      release_ok |-> stable && pll_en_o;
   endproperty
   a_gate: assert property (p_gate) else $error("release before pll stable");

   property p_ack;
      bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("wishbone ack timing");

   c_pd_wake: cover property ((s_ff.seq == SEQ_DOWN) ##1 (s_ff.seq == SEQ_PRELOAD));
   c_run: cover property ((s_ff.seq == SEQ_LOCK) ##1 (s_ff.seq == SEQ_RUN));
   c_bypass: cover property (bypass && release_ok);
   c_exit: cover property ($rose(s_ff.strap_exit));
endmodule

/* File: rtl/clkgen_pkg.sv */
package clkgen_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int REF_XTAL_MHZ = 25;
   localparam int LOCK_TIME_US = 100;
   localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
   localparam int FS_HOLD_NS = 1000;
   localparam int FS_HOLD_CYCLES = (FS_HOLD_NS * CLK_MHZ) / 1000;

   // ----------------------------------------------------------------
   // banks and select pins
   // ----------------------------------------------------------------
   localparam int NUM_BANKS = 4;
   localparam int FS_W = 4;
   localparam logic [1:0] LVL_LOW = 2'h0;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] SEL_OFS = 8'h08;
   localparam int CTRL_BYPASS_BIT = 0;
   localparam int CTRL_BYP_PECL_BIT = 1;
   localparam int CTRL_PD_BIT = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_STABLE_BIT = 1;
   localparam int STAT_STRAP_BIT = 2;
   localparam int STAT_DOWN_BIT = 3;
   localparam int STAT_REFSEL_BIT = 4;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // power sequencer states
   typedef enum {SEQ_DOWN, SEQ_PRELOAD, SEQ_LOCK, SEQ_RUN} seq_state_type;

   // output type from a bank's select code: only the last bank can be lvcmos
   function automatic logic bank_pecl(input int idx, input logic [FS_W-1:0] code);
      return (idx != NUM_BANKS - 1) || (code[3:2] != LVL_LOW);
   endfunction

endpackage

/* File: rtl/bank_ctrl_if.sv */
`timescale 1ns/1ps
interface bank_ctrl_if;
   import clkgen_pkg::*;
   logic preload;
   logic release_ok;
   logic live;
   logic bypass;
   logic bypass_pecl;
   logic ref_lvl;
   logic [FS_W-1:0] fs;
   logic [FS_W-1:0] sel;
   logic pecl;
   logic running;
   logic out_a;
   logic out_b;
   modport ctrl (output preload, release_ok, live, bypass, bypass_pecl, ref_lvl, fs,
      input sel, pecl, running, out_a, out_b);
   modport bank (input preload, release_ok, live, bypass, bypass_pecl, ref_lvl, fs,
      output sel, pecl, running, out_a, out_b);
endinterface

/* File: rtl/lock_timer.sv */
`timescale 1ns/1ps
module lock_timer import clkgen_pkg::*; #(
   parameter int CYCLES = LOCK_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   output logic stable_o
);
   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic stable;
   } timer_state_type;

   timer_state_type s_ff;
   timer_state_type nxt_s;

   // count from the start of the pll; stable once the lock time ran out
   always_comb begin
      nxt_s = s_ff;
      if (!run_i) begin
         nxt_s = '0;
      end else if (!s_ff.stable) begin
         nxt_s.cnt = s_ff.cnt + CW'(1);
         if (s_ff.cnt == CW'(CYCLES - 1)) begin
            nxt_s.stable = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign stable_o = s_ff.stable;
endmodule

/* File: rtl/bank_channel.sv */
`timescale 1ns/1ps
module bank_channel import clkgen_pkg::*; #(
   parameter int IDX = 0,
   parameter int HOLD = FS_HOLD_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control from the sequencer
   bank_ctrl_if.bank b
);
   typedef struct packed {
      logic [FS_W-1:0] sel;
      logic pecl;
      logic [7:0] hold;
      logic [FS_W-1:0] div;
      logic phase;
      logic running;
      logic a;
      logic b;
   } bank_state_type;

   bank_state_type s_ff;
   bank_state_type nxt_s;

   // select latch, refresh hold, divider and output levels
   always_comb begin
      logic src;
      logic pecl_eff;
      src = 1'b0;
      pecl_eff = 1'b1;
      nxt_s = s_ff;
      nxt_s.div = s_ff.div + 4'h1;
      if (s_ff.div >= s_ff.sel) begin
         nxt_s.div = 4'h0;
         nxt_s.phase = ~s_ff.phase;
      end
      if (b.preload) begin
         nxt_s.sel = b.fs;
         nxt_s.pecl = bank_pecl(IDX, b.fs);
         nxt_s.hold = 8'h00;
      end else if (b.live && b.release_ok && (b.fs != s_ff.sel)) begin
         nxt_s.sel = b.fs;
         nxt_s.pecl = bank_pecl(IDX, b.fs);
         nxt_s.hold = 8'(HOLD);
      end else if (s_ff.hold != 8'h00) begin
         nxt_s.hold = s_ff.hold - 8'h01;
      end
      // the new hold count gates the outputs, so a select change goes static at once
      if (!b.release_ok || (nxt_s.hold != 8'h00)) begin
         nxt_s.a = 1'b0;
         nxt_s.b = 1'b1;
         nxt_s.running = 1'b0;
      end else begin
         src = b.bypass ? b.ref_lvl : s_ff.phase;
         pecl_eff = b.bypass ? b.bypass_pecl : s_ff.pecl;
         nxt_s.a = src;
         nxt_s.b = pecl_eff ? ~src : src;
         nxt_s.running = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_ff <= '{sel: '0, pecl: 1'b1, hold: '0, div: '0, phase: 1'b0,
                   running: 1'b0, a: 1'b0, b: 1'b1};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // results back to the sequencer
   assign b.sel = s_ff.sel;
   assign b.pecl = s_ff.pecl;
   assign b.running = s_ff.running;
   assign b.out_a = s_ff.a;
   assign b.out_b = s_ff.b;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_static_hold;
      !b.release_ok |=> (s_ff.a == 1'b0) && (s_ff.b == 1'b1);
   endproperty
   a_static_hold: assert property (p_static_hold) else $error("bank not static");

   property p_refresh;
      (b.live && b.release_ok && !b.preload && (b.fs != s_ff.sel))
         |=> !s_ff.running [*2];
   endproperty
   a_refresh: assert property (p_refresh) else $error("no static gap");

   property p_bypass;
      (b.bypass && b.release_ok && (s_ff.hold == 8'h00)) |=> s_ff.a == $past(b.ref_lvl);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not following ref");

   property p_type;
      (!b.bypass && b.release_ok && (s_ff.hold == 8'h00) && s_ff.pecl && !b.preload
       && !b.live) |=> s_ff.b == ~s_ff.a;
   endproperty
   a_type: assert property (p_type) else $error("pecl pair not complementary");

   c_refresh: cover property (b.live && b.release_ok && (b.fs != s_ff.sel));
endmodule

/* File: tb/board_strap_host.sv */
`timescale 1ns/1ps
module board_strap_host import clkgen_pkg::*; (
   // clock
   input wire logic clk_i,
   // strap and serial lines
   output logic ref_source_select_o,
   output logic sda_o,
   output logic clock_or_powerdown_pin_o,
   output logic mixed_mode_o,
   output logic [NUM_BANKS*FS_W-1:0] freq_select_pins_o,
   // reference
   output logic ref_in_true_o,
   output logic ref_in_comp_o
);
   logic single_ff = 1'b0;
   logic [1:0] div_ff = 2'h0;
   logic true_ff = 1'b0;

   initial begin
      ref_source_select_o = 1'b0;
      sda_o = 1'b0;
      clock_or_powerdown_pin_o = 1'b0;
      mixed_mode_o = 1'b0;
      freq_select_pins_o = 16'h1210;
   end

   // reference oscillator, half period of two clocks
   always @(posedge clk_i) begin
      div_ff <= div_ff + 2'h1;
      if (div_ff[0]) begin
         true_ff <= ~true_ff;
      end
   end

   // true on the first pin, complement or ground on the second
   assign ref_in_true_o = true_ff;
   assign ref_in_comp_o = single_ff ? 1'b0 : ~true_ff;

   // reference path straps; single-ended also needs select high
   task automatic set_ref(input logic sel, input logic single);
      @(posedge clk_i);
      ref_source_select_o <= sel | single;
      single_ff <= single;
   endtask

   // data line, power-down pin and mixed-mode pin
   task automatic set_lines(input logic sda, input logic pd, input logic mm);
      @(posedge clk_i);
      sda_o <= sda;
      clock_or_powerdown_pin_o <= pd;
      mixed_mode_o <= mm;
   endtask

   // select straps; callers change frequency only, never the type
   task automatic set_fs(input logic [15:0] v);
      @(posedge clk_i);
      freq_select_pins_o <= v;
   endtask
endmodule

/* File: tb/clock_gen_mode_sequencer_tb.sv */
`timescale 1ns/1ps
module clock_gen_mode_sequencer_tb;
   import clkgen_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat, rd;
   logic ack, rsel, sda, pd, mm, rt, rc, xen, den, ldo, pen, stable;
   logic [15:0] fs;
   logic [3:0] out_a, out_b, pecl;
   logic [2:0] hist;
   int error_cnt = 0;
   int check_count = 0;

   always #5 clk_i = ~clk_i;

   board_strap_host host (.clk_i(clk_i), .ref_source_select_o(rsel), .sda_o(sda),
      .clock_or_powerdown_pin_o(pd), .mixed_mode_o(mm), .freq_select_pins_o(fs),
      .ref_in_true_o(rt), .ref_in_comp_o(rc));

   clock_gen_mode_sequencer #(.LOCK_CYC(20)) uut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ref_source_select_i(rsel),
      .sda_i(sda), .clock_or_powerdown_pin_i(pd), .mixed_mode_i(mm),
      .freq_select_pins_i(fs), .ref_in_true_i(rt), .ref_in_comp_i(rc),
      .xtal_osc_en_o(xen), .diff_buf_en_o(den), .ldo_en_o(ldo), .pll_en_o(pen),
      .pll_stable_o(stable), .bank_out_a_o(out_a), .bank_out_b_o(out_b),
      .bank_is_pecl_o(pecl));

   // ----------------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // one classic cycle; request held until ack is sampled
   task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = rdat;
      chk("wb_ack", 32'h1, {31'h0, ack});
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // bounded wait for the pll stable flag
   task automatic wait_stable();
      int n;
      n = 0;
      while (stable !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      chk("pll_stable", 32'h1, {31'h0, stable});
      repeat (3) @(posedge clk_i);
   endtask

   // counts bank toggles and checks a/b pairing for the bank type
   task automatic tog(input int k, input int cycles, input int exp_n);
      logic p;
      int n, bad;
      n = 0;
      bad = 0;
      p = out_a[k];
      repeat (cycles) begin
         @(posedge clk_i);
         if (out_a[k] !== p) n++;
         p = out_a[k];
         if (pecl[k] ? (out_b[k] !== ~out_a[k]) : (out_b[k] !== out_a[k])) bad++;
      end
      chk("toggles", exp_n, n);
      chk("pairing", 32'h0, bad);
   endtask

   task automatic static_banks();
      chk("out_a", 32'h0, {28'h0, out_a});
      chk("out_b", 32'h0000_000f, {28'h0, out_b});
   endtask

   // ----------------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      $display("CHECK FAILED watchdog expected done seen hang");
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (11) @(posedge clk_i);
      static_banks();
      @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("xtal_en", 32'h1, {31'h0, xen});
      chk("diff_en", 32'h0, {31'h0, den});
      chk("ldo_en", 32'h1, {31'h0, ldo});
      chk("stable", 32'h0, {31'h0, stable});
      repeat (8) @(posedge clk_i);
      static_banks();
      wait_stable();
      chk("pecl", 32'h7, {28'h0, pecl});
      wb_xfer(1'b0, SEL_OFS, 32'h0);
      chk("sel_reg", 32'h000f_1210, rd);
      wb_xfer(1'b0, STAT_OFS, 32'h0);
      chk("status", 32'h0000_0007, rd);
      tog(0, 12, 12);
      tog(1, 12, 6);
      tog(2, 12, 4);
      tog(3, 12, 6);
      // select change on bank one only
      host.set_fs(16'h1220);
      repeat (5) @(posedge clk_i);
      chk("bank1_a", 32'h0, {31'h0, out_a[1]});
      chk("bank1_b", 32'h1, {31'h0, out_b[1]});
      tog(0, 12, 12);
      repeat (100) @(posedge clk_i);
      tog(1, 12, 4);
      // pin power-down, new selects while down, wake
      host.set_lines(1'b0, 1'b1, 1'b0);
      repeat (4) @(posedge clk_i);
      chk("ldo_off", 32'h0, {31'h0, ldo});
      chk("pll_off", 32'h0, {31'h0, pen});
      chk("xtal_off", 32'h0, {31'h0, xen});
      static_banks();
      wb_xfer(1'b0, STAT_OFS, 32'h0);
      chk("down_bit", 32'h1, {31'h0, rd[STAT_DOWN_BIT]});
      host.set_fs(16'h2110);
      host.set_lines(1'b0, 1'b0, 1'b0);
      repeat (10) @(posedge clk_i);
      chk("relock", 32'h0, {31'h0, stable});
      wait_stable();
      wb_xfer(1'b0, SEL_OFS, 32'h0);
      chk("sel_reload", 32'h000f_2110, rd);
      // power cycle with single-ended reference
      host.set_ref(1'b0, 1'b1);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk("stable_rst", 32'h0, {31'h0, stable});
      chk("diff_en", 32'h1, {31'h0, den});
      chk("xtal_en", 32'h0, {31'h0, xen});
      wait_stable();
      tog(0, 12, 12);
      // register power-down
      wb_xfer(1'b1, CTRL_OFS, 32'h0000_0004);
      repeat (3) @(posedge clk_i);
      chk("ldo_reg_pd", 32'h0, {31'h0, ldo});
      wb_xfer(1'b1, CTRL_OFS, 32'h0);
      wait_stable();
      // data line high leaves strap mode for good
      host.set_lines(1'b1, 1'b0, 1'b1);
      host.set_lines(1'b0, 1'b1, 1'b1);
      repeat (5) @(posedge clk_i);
      chk("no_pin_pd", 32'h1, {31'h0, ldo});
      wb_xfer(1'b0, STAT_OFS, 32'h0);
      chk("strap_bit", 32'h0, {31'h0, rd[STAT_STRAP_BIT]});
      host.set_lines(1'b0, 1'b0, 1'b1);
      // bypass in both output types
      for (int t = 0; t < 2; t++) begin
         host.set_ref(1'b1, !t[0]);
         wb_xfer(1'b1, CTRL_OFS, {30'h0, t[0], 1'b1});
         // prefill the two-cycle reference history before comparing
         repeat (4) begin
            @(posedge clk_i);
            hist = {hist[1:0], rt};
         end
         repeat (16) begin
            @(posedge clk_i);
            hist = {hist[1:0], rt};
            chk("byp_a", {31'h0, hist[2]}, {31'h0, out_a[0]});
            chk("byp_b", {31'h0, hist[2] ^ t[0]}, {31'h0, out_b[0]});
         end
      end
      wb_xfer(1'b1, CTRL_OFS, 32'h0);
      host.set_lines(1'b0, 1'b0, 1'b0);
      repeat (5) @(posedge clk_i);
      static_banks();
      wb_xfer(1'b1, 8'h0c, 32'hffff_ffff);
      wb_xfer(1'b0, 8'h0c, 32'h0);
      chk("unmapped", 32'h0, rd);
      tally_and_finish();
   end
endmodule
